// >>> rtl/spi_port_pkg.sv
// Package of register offsets, field positions, reset values and timing
package spi_port_pkg;
	// ==========================================================
	// Register offsets in the special-function-register space
	localparam logic [7:0] TX_DATA_OFS = 8'he6;
	localparam logic [7:0] RX_DATA_OFS = 8'he7;
	localparam logic [7:0] CFG_OFS = 8'he9;
	localparam logic [7:0] STATUS_OFS = 8'hea;
	// ==========================================================
	// Configuration field positions
	localparam int CFG_TRIGGER_BIT = 0;
	localparam int CFG_LSB_FIRST_BIT = 1;
	localparam int CFG_MASTER_BIT = 2;
	localparam int CFG_SS_IN_EN_BIT = 3;
	localparam int CFG_OVERWRITE_BIT = 4;
	localparam logic [7:0] CFG_RESET = 8'h00;
	// ==========================================================
	// Status field positions
	localparam int ST_BUSY_BIT = 7;
	localparam int ST_MULTI_MASTER_ERROR_BIT = 6;
	localparam int ST_RXOF_BIT = 5;
	localparam int ST_RXIRQ_BIT = 4;
	localparam int ST_RXFULL_BIT = 3;
	localparam int ST_TXIRQ_BIT = 1;
	localparam int ST_TXFULL_BIT = 0;
	localparam logic [7:0] DATA_RESET = 8'h00;
	// ==========================================================
	// Timing: master serial clock half period; also bits per byte and transmit FIFO depth
	localparam int CLOCK_NS = 25;
	localparam int SCLK_HALF_NS = 100;
	localparam int SCLK_HALF_CYC = (SCLK_HALF_NS / CLOCK_NS < 1) ? 1 :
		SCLK_HALF_NS / CLOCK_NS;
	localparam int BITS_PER_BYTE = 8;
	localparam int TX_FIFO_DEPTH = 4;
endpackage

// >>> rtl/spi_tx_fifo.sv
// Small parameterised FIFO between the transmit register and the shifter
`timescale 1ns/1ps
`default_nettype none
module spi_tx_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Draining side
	input wire logic out_ready,
	output logic out_valid,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [AW:0] cnt_q, cnt_d;
	logic push, pop;

	// Honest full and empty come straight from the fill count
	assign in_ready = (cnt_q != AW'(0) + (AW+1)'(DEPTH)) ? 1'b1 : 1'b0;
	assign out_valid = (cnt_q != '0);
	assign out_data = mem_q[rd_q];
	assign push = in_valid && in_ready;
	assign pop = out_ready && out_valid;

	// Pointer and count update, wrapping at the depth
	always_comb begin
		wr_d = wr_q;
		rd_d = rd_q;
		cnt_d = cnt_q;
		if (push) begin
			wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
		end
		if (pop) begin
			rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
		end
		if (push && !pop) begin
			cnt_d = cnt_q + 1'b1;
		end else if (pop && !push) begin
			cnt_d = cnt_q - 1'b1;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
		end
	end

	// Storage carries no reset; only written entries are ever read
	always_ff @(posedge clock) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end
endmodule
`default_nettype wire

// >>> rtl/spi_port.sv
// Byte-wide serial port: transfer mode, bit order and status flags
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Bit order: 0 sends MSB first, 1 LSB
// - Mode 0: receive-register read starts transfer, irq
// - Mode 1: transmit write starts transfer, empty irq
// - Status bit 7 busy while moving data
// - Select asserted during master transfer sets bit 6
// - Unread receive byte at next end: bit 5
// - Overflow overwrites only when overwrite enabled
// - Receive-register read clears status bit 4
// - Bit 4 zero when no unread byte
// - Mode 0 stops when byte left unread
// - Transmit write clears transmit interrupt flag
module spi_port (
	// Clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// Special-function-register port
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	// Interrupt request to the core
	output logic irq_req,
	// Serial pins, each as input, output and enable
	input wire logic sclk_i,
	output logic sclk_o,
	output logic sclk_oe,
	input wire logic mosi_i,
	output logic mosi_o,
	output logic mosi_oe,
	input wire logic miso_i,
	output logic miso_o,
	output logic miso_oe,
	input wire logic ss_n_i,
	output logic ss_n_o,
	output logic ss_n_oe
);
	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_XFER = 1'b1
	} state_t;

	// ==========================================================
	// Pin synchronisers: sclk, mosi, miso, ss_n
	logic [3:0] pin_raw, s1_q, s2_q;
	logic sclk_s3_q;
	assign pin_raw = {ss_n_i, miso_i, mosi_i, sclk_i};
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_sync
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					// Select idles high; a low start would fake a select
					s1_q[g] <= (g == 3) ? 1'b1 : 1'b0;
					s2_q[g] <= (g == 3) ? 1'b1 : 1'b0;
				end else begin
					s1_q[g] <= pin_raw[g];
					s2_q[g] <= s1_q[g];
				end
			end
		end
	endgenerate

	// ==========================================================
	// State
	state_t state_q, state_d;
	logic [7:0] cfg_q, cfg_d, rx_q, rx_d, sh_q, sh_d, rdata_q, rdata_d;
	logic [2:0] bit_q, bit_d;
	logic [15:0] div_q, div_d;
	logic in_bit_q, in_bit_d, sclk_q, sclk_d, go_q, go_d;
	logic busy_q, busy_d, multi_master_error_q, multi_master_error_d, rxof_q, rxof_d;
	logic rxirq_q, rxirq_d, txirq_q, txirq_d, irq_q, irq_d;
	logic out_q, out_d, mosi_oe_q, mosi_oe_d, miso_oe_q, miso_oe_d;
	logic ssn_q, ssn_d, ss_oe_q, ss_oe_d;
	logic wr_tx, wr_cfg, rd_rx, rd_st, rise, fall, done, load;
	logic fifo_valid, fifo_ready, fifo_pop;
	logic [7:0] fifo_data, rx_byte;
	logic master, lsb, transfer_trigger_select, ss_act;

	assign master = cfg_q[spi_port_pkg::CFG_MASTER_BIT];
	assign lsb = cfg_q[spi_port_pkg::CFG_LSB_FIRST_BIT];
	assign transfer_trigger_select = cfg_q[spi_port_pkg::CFG_TRIGGER_BIT];
	assign ss_act = !s2_q[3];
	assign wr_tx = sfr_wr && (sfr_addr == spi_port_pkg::TX_DATA_OFS);
	assign wr_cfg = sfr_wr && (sfr_addr == spi_port_pkg::CFG_OFS);
	assign rd_rx = sfr_rd && (sfr_addr == spi_port_pkg::RX_DATA_OFS);
	assign rd_st = sfr_rd && (sfr_addr == spi_port_pkg::STATUS_OFS);

	// Transmit words queue here; a full queue shows in status bit 0
	spi_tx_fifo #(
		.WIDTH(8),
		.DEPTH(spi_port_pkg::TX_FIFO_DEPTH)
	) u_tx_fifo (
		.clock(clock),
		.rst_n(rst_n),
		.in_valid(wr_tx),
		.in_ready(fifo_ready),
		.in_data(sfr_wdata),
		.out_ready(fifo_pop),
		.out_valid(fifo_valid),
		.out_data(fifo_data)
	);

	// Edges: master from its own divider, slave from the synced pin
	always_comb begin
		if (master) begin
			rise = (state_q == ST_XFER) && (div_q == '0) && !sclk_q;
			fall = (state_q == ST_XFER) && (div_q == '0) && sclk_q;
		end else begin
			rise = (state_q == ST_XFER) && s2_q[0] && !sclk_s3_q;
			fall = (state_q == ST_XFER) && !s2_q[0] && sclk_s3_q;
		end
		done = fall && (bit_q == 3'(spi_port_pkg::BITS_PER_BYTE - 1));
		rx_byte = lsb ? {in_bit_q, sh_q[7:1]} : {sh_q[6:0], in_bit_q};
	end

	// Next-state logic for the shifter, flags and register file
	always_comb begin
		state_d = state_q;
		cfg_d = cfg_q;
		rx_d = rx_q;
		sh_d = sh_q;
		bit_d = bit_q;
		div_d = div_q;
		in_bit_d = in_bit_q;
		sclk_d = sclk_q;
		go_d = go_q;
		multi_master_error_d = multi_master_error_q;
		rxof_d = rxof_q;
		rxirq_d = rxirq_q;
		txirq_d = txirq_q;
		load = 1'b0;
		if (wr_cfg) begin
			cfg_d = sfr_wdata;
		end
		// Reads clear; a same-cycle hardware set below still wins
		if (rd_rx) begin
			rxirq_d = 1'b0;
		end
		if (rd_st) begin
			rxof_d = 1'b0;
			multi_master_error_d = 1'b0;
		end
		if (wr_tx) begin
			txirq_d = 1'b0;
		end else if (!fifo_valid) begin
			txirq_d = 1'b1;
		end
		// Master divider runs only inside a transfer
		if (state_q == ST_XFER && master) begin
			if (div_q == '0) begin
				div_d = 16'(spi_port_pkg::SCLK_HALF_CYC - 1);
				sclk_d = !sclk_q;
			end else begin
				div_d = div_q - 1'b1;
			end
		end
		if (rise) begin
			in_bit_d = master ? s2_q[2] : s2_q[1];
		end
		if (fall) begin
			sh_d = rx_byte;
			bit_d = bit_q + 1'b1;
		end
		if (done) begin
			// Unread byte at the end of the next one is an overflow
			if (rxirq_q && !rd_rx) begin
				rxof_d = 1'b1;
			end
			if (!rxirq_q || rd_rx || cfg_q[spi_port_pkg::CFG_OVERWRITE_BIT]) begin
				rx_d = rx_byte;
			end
			rxirq_d = 1'b1;
		end
		case (state_q)
			ST_IDLE: begin
				sclk_d = 1'b0;
				div_d = 16'(spi_port_pkg::SCLK_HALF_CYC - 1);
				if (master && (transfer_trigger_select ? fifo_valid : go_q)) begin
					load = 1'b1;
					go_d = 1'b0;
				end else if (!master && ss_act) begin
					load = 1'b1;
				end
			end
			ST_XFER: begin
				if (master && cfg_q[spi_port_pkg::CFG_SS_IN_EN_BIT] && ss_act) begin
					multi_master_error_d = 1'b1;
					state_d = ST_IDLE;
				end else if (!master && !ss_act) begin
					state_d = ST_IDLE;
				end else if (done) begin
					// Mode 0 only goes on once the last byte was read
					state_d = ST_IDLE;
					if (master && (transfer_trigger_select ? fifo_valid : go_q)) begin
						load = 1'b1;
						go_d = 1'b0;
					end else if (!master) begin
						load = 1'b1;
					end
				end
			end
			default: state_d = ST_IDLE;
		endcase
		// Mode 0: a receive read asks for a byte; it outlives a load
		if (rd_rx && !transfer_trigger_select) begin
			go_d = 1'b1;
		end
		if (load) begin
			state_d = ST_XFER;
			sh_d = fifo_valid ? fifo_data : spi_port_pkg::DATA_RESET;
			bit_d = '0;
		end
	end
	assign fifo_pop = load && fifo_valid;

	// Registered pins, status and read data
	always_comb begin
		out_d = lsb ? sh_d[0] : sh_d[7];
		busy_d = (state_d == ST_XFER);
		mosi_oe_d = master;
		miso_oe_d = !master && ss_act;
		ss_oe_d = master && !cfg_d[spi_port_pkg::CFG_SS_IN_EN_BIT];
		ssn_d = !(master && state_d == ST_XFER);
		irq_d = transfer_trigger_select ? txirq_d : rxirq_d;
		rdata_d = 8'h00;
		case (sfr_addr)
			spi_port_pkg::RX_DATA_OFS: rdata_d = rx_q;
			spi_port_pkg::CFG_OFS: rdata_d = cfg_q;
			spi_port_pkg::STATUS_OFS: begin
				rdata_d[spi_port_pkg::ST_BUSY_BIT] = busy_q;
				rdata_d[spi_port_pkg::ST_MULTI_MASTER_ERROR_BIT] = multi_master_error_q;
				rdata_d[spi_port_pkg::ST_RXOF_BIT] = rxof_q;
				rdata_d[spi_port_pkg::ST_RXIRQ_BIT] = rxirq_q;
				rdata_d[spi_port_pkg::ST_RXFULL_BIT] = rxirq_q;
				rdata_d[spi_port_pkg::ST_TXIRQ_BIT] = txirq_q;
				rdata_d[spi_port_pkg::ST_TXFULL_BIT] = !fifo_ready;
			end
			default: rdata_d = 8'h00;
		endcase
	end

	// Every flag starts clear so nothing is reported before it happens
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_IDLE;
			cfg_q <= spi_port_pkg::CFG_RESET;
			rx_q <= spi_port_pkg::DATA_RESET;
			sh_q <= spi_port_pkg::DATA_RESET;
			rdata_q <= 8'h00;
			bit_q <= '0;
			div_q <= '0;
			in_bit_q <= 1'b0;
			sclk_q <= 1'b0;
			sclk_s3_q <= 1'b0;
			go_q <= 1'b0;
			busy_q <= 1'b0;
			multi_master_error_q <= 1'b0;
			rxof_q <= 1'b0;
			rxirq_q <= 1'b0;
			txirq_q <= 1'b0;
			irq_q <= 1'b0;
			out_q <= 1'b0;
			mosi_oe_q <= 1'b0;
			miso_oe_q <= 1'b0;
			ssn_q <= 1'b1;
			ss_oe_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cfg_q <= cfg_d;
			rx_q <= rx_d;
			sh_q <= sh_d;
			rdata_q <= rdata_d;
			bit_q <= bit_d;
			div_q <= div_d;
			in_bit_q <= in_bit_d;
			sclk_q <= sclk_d;
			sclk_s3_q <= s2_q[0];
			go_q <= go_d;
			busy_q <= busy_d;
			multi_master_error_q <= multi_master_error_d;
			rxof_q <= rxof_d;
			rxirq_q <= rxirq_d;
			txirq_q <= txirq_d;
			irq_q <= irq_d;
			out_q <= out_d;
			mosi_oe_q <= mosi_oe_d;
			miso_oe_q <= miso_oe_d;
			ssn_q <= ssn_d;
			ss_oe_q <= ss_oe_d;
		end
	end

	assign sfr_rdata = rdata_q;
	assign irq_req = irq_q;
	assign sclk_o = sclk_q;
	assign sclk_oe = mosi_oe_q;
	assign mosi_o = out_q;
	assign mosi_oe = mosi_oe_q;
	assign miso_o = out_q;
	assign miso_oe = miso_oe_q;
	assign ss_n_o = ssn_q;
	assign ss_n_oe = ss_oe_q;

	// ==========================================================
	// Assertions
	property p_order;
		@(posedge clock) disable iff (!rst_n)
		load |=> out_q == (lsb ? sh_q[0] : sh_q[7]);
	endproperty
	a_order: assert property (p_order) else $error("bad bit order");
	property p_mode0_start;
		@(posedge clock) disable iff (!rst_n)
		state_q == ST_IDLE && master && !transfer_trigger_select && !go_q && !ss_act
		|=> state_q == ST_IDLE;
	endproperty
	a_mode0_start: assert property (p_mode0_start) else $error("mode0 start");
	property p_txirq_set;
		@(posedge clock) disable iff (!rst_n)
		!wr_tx && !fifo_valid |=> txirq_q;
	endproperty
	a_txirq_set: assert property (p_txirq_set) else $error("tx irq");
	property p_busy;
		@(posedge clock) disable iff (!rst_n)
		##1 busy_q == (state_q == ST_XFER);
	endproperty
	a_busy: assert property (p_busy) else $error("busy wrong");
	property p_multi_master_error;
		@(posedge clock) disable iff (!rst_n)
		state_q == ST_XFER && master && ss_act &&
		cfg_q[spi_port_pkg::CFG_SS_IN_EN_BIT] |=> multi_master_error_q && state_q == ST_IDLE;
	endproperty
	a_multi_master_error: assert property (p_multi_master_error) else $error("multi_master_error missed");
	property p_ovf;
		@(posedge clock) disable iff (!rst_n)
		done && rxirq_q && !rd_rx |=> rxof_q;
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow missed");
	property p_keep;
		@(posedge clock) disable iff (!rst_n)
		done && rxirq_q && !rd_rx && !cfg_q[spi_port_pkg::CFG_OVERWRITE_BIT]
		|=> $stable(rx_q);
	endproperty
	a_keep: assert property (p_keep) else $error("rx overwritten");
	property p_rdclr;
		@(posedge clock) disable iff (!rst_n)
		rd_rx && !done |=> !rxirq_q;
	endproperty
	a_rdclr: assert property (p_rdclr) else $error("rx irq not cleared");
	property p_txclr;
		@(posedge clock) disable iff (!rst_n)
		wr_tx |=> !txirq_q;
	endproperty
	a_txclr: assert property (p_txclr) else $error("tx irq not cleared");
	c_master_byte: cover property (@(posedge clock) disable iff (!rst_n)
		done && master);
	c_slave_byte: cover property (@(posedge clock) disable iff (!rst_n)
		done && !master);
	c_overflow: cover property (@(posedge clock) disable iff (!rst_n)
		$rose(rxof_q));
	c_multi_master_error: cover property (@(posedge clock) disable iff (!rst_n)
		$rose(multi_master_error_q));
endmodule
`default_nettype wire

// >>> sim/spi_slave_model.sv
// Behavioural external serial slave on the far side of the port
`timescale 1ns/1ps
`default_nettype none
module spi_slave_model (
	// Serial pins seen from the slave
	input wire logic sclk,
	input wire logic ss_n,
	input wire logic mosi,
	output logic miso,
	// Byte to send and last byte taken
	input wire logic [7:0] tx_byte,
	output logic [7:0] rx_byte,
	output int n_bytes
);
	logic [7:0] sh;
	logic [7:0] rsh;
	int bitc;
	// ==========================================================
	// Power-up state
	initial begin
		miso = 1'b0;
		rx_byte = 8'h00;
		n_bytes = 0;
		bitc = 0;
	end
	// Selection loads the byte so its first bit shows before the rise
	always @(negedge ss_n) begin
		sh = tx_byte;
		bitc = 0;
		miso = sh[7];
	end
	// Released line shows the inverse, so a stale bit never passes
	always @(posedge ss_n) begin
		miso = ~miso;
	end
	// Sample on the rise, first bit taken as the MSB
	always @(posedge sclk) begin
		if (!ss_n) begin
			rsh = {rsh[6:0], mosi};
			bitc = bitc + 1;
			if (bitc == 8) begin
				rx_byte = rsh;
				n_bytes++;
				bitc = 0;
			end
		end
	end
	// Change on the fall; a fresh byte is loaded after the eighth bit
	always @(negedge sclk) begin
		if (!ss_n) begin
			if (bitc == 0) sh = tx_byte;
			miso = sh[7 - bitc];
		end
	end
endmodule
`default_nettype wire

// >>> sim/tb.sv
// Self-checking bench for the serial port
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] sfr_addr = 8'h00;
	logic [7:0] sfr_wdata = 8'h00;
	logic sfr_wr = 1'b0;
	logic sfr_rd = 1'b0;
	logic ss_force = 1'b0;
	logic m_sclk = 1'b0;
	logic m_mosi = 1'b1;
	logic [7:0] sfr_rdata;
	logic irq_req, sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe;
	logic ss_n_o, ss_n_oe, m_miso;
	logic [7:0] m_tx = 8'h12;
	logic [7:0] m_rx;
	logic [7:0] v;
	int m_n, n0;
	int num_errors = 0;
	int n_tests = 0;
	// Pin levels from every party's enable; the bench masters a slave port
	wire logic sclk_w = sclk_oe ? sclk_o : m_sclk;
	wire logic mosi_w = mosi_oe ? mosi_o : m_mosi;
	wire logic miso_w = miso_oe ? miso_o : m_miso;
	wire logic ss_w = ss_force ? 1'b0 : (ss_n_oe ? ss_n_o : 1'b1);
	// ==========================================================
	// Clock, 25 ns period
	always #12.5 clock = ~clock;
`define CHECK(g, e, m) begin n_tests++; if ((g) !== (e)) begin \
	num_errors++; $display("[FAIL] %0t %s", $time, m); end end
	spi_port u_spi_port (.clock(clock), .rst_n(rst_n),
		.sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
		.sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .irq_req(irq_req),
		.sclk_i(sclk_w), .sclk_o(sclk_o), .sclk_oe(sclk_oe),
		.mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
		.miso_i(miso_w), .miso_o(miso_o), .miso_oe(miso_oe),
		.ss_n_i(ss_w), .ss_n_o(ss_n_o), .ss_n_oe(ss_n_oe));
	spi_slave_model u_spi_slave_model (.sclk(sclk_w), .ss_n(ss_n_o),
		.mosi(mosi_w), .miso(m_miso), .tx_byte(m_tx), .rx_byte(m_rx),
		.n_bytes(m_n));
	// ==========================================================
	// Shared tasks
	task automatic final_report();
		$display("errors %0d checks %0d", num_errors, n_tests);
		if (num_errors == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock); #2;
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(posedge clock); #2;
		sfr_wr = 1'b0;
	endtask
	// Read data is registered, so it is taken one edge after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock); #2;
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(posedge clock); #2;
		sfr_rd = 1'b0;
		d = sfr_rdata;
	endtask
	// Bounded wait for the slave to count n bytes, then let flags land
	task automatic wait_bytes(input int n);
		int i;
		for (i = 0; i < 3000 && m_n < n; i++) @(posedge clock);
		if (m_n < n) begin
			num_errors++;
			$display("[FAIL] %0t wait bound used up", $time);
			final_report();
		end
		repeat (8) @(posedge clock);
		#2;
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_reset();
		rd(spi_port_pkg::STATUS_OFS, v);
		`CHECK(v[7:3], 5'h00, "status flags after reset")
		rd(8'h00, v);
		`CHECK(v, 8'h00, "unmapped read")
	endtask
	// Both bit orders, master transfer started by a transmit write
	task automatic t_order();
		int k;
		for (k = 0; k < 2; k++) begin
			n0 = m_n;
			wr(spi_port_pkg::CFG_OFS, k ? 8'h07 : 8'h05);
			wr(spi_port_pkg::TX_DATA_OFS, 8'hc1);
			repeat (4) @(posedge clock);
			rd(spi_port_pkg::STATUS_OFS, v);
			`CHECK(v[7], 1'b1, "busy during byte")
			wait_bytes(n0 + 1);
			`CHECK(m_rx, k ? 8'h83 : 8'hc1, "bits out")
			`CHECK(irq_req, 1'b1, "irq on empty transmit")
			rd(spi_port_pkg::STATUS_OFS, v);
			`CHECK(v[7], 1'b0, "idle after byte")
			`CHECK(v[4], 1'b1, "receive flag on new byte")
			rd(spi_port_pkg::RX_DATA_OFS, v);
			`CHECK(v, k ? 8'h48 : 8'h12, "bits in")
			rd(spi_port_pkg::STATUS_OFS, v);
			`CHECK(v[4], 1'b0, "receive flag after read")
		end
	endtask
	// Second byte lands on an unread one, with and without overwrite
	task automatic t_overflow(input logic ow);
		n0 = m_n;
		wr(spi_port_pkg::CFG_OFS, ow ? 8'h15 : 8'h05);
		m_tx = 8'h66;
		wr(spi_port_pkg::TX_DATA_OFS, 8'h01);
		repeat (8) @(posedge clock);
		m_tx = 8'h99;
		wr(spi_port_pkg::TX_DATA_OFS, 8'h02);
		wait_bytes(n0 + 2);
		rd(spi_port_pkg::STATUS_OFS, v);
		`CHECK(v[5], 1'b1, "overflow on unread byte")
		rd(spi_port_pkg::STATUS_OFS, v);
		`CHECK(v[5], 1'b0, "overflow after status read")
		rd(spi_port_pkg::RX_DATA_OFS, v);
		`CHECK(v, ow ? 8'h99 : 8'h66, "overwrite choice")
	endtask
	// Fill the transmit buffer past its depth; the extra word is dropped
	task automatic t_fill();
		int i;
		n0 = m_n;
		wr(spi_port_pkg::CFG_OFS, 8'h05);
		for (i = 0; i < 6; i++) wr(spi_port_pkg::TX_DATA_OFS, 8'h20 + 8'(i));
		rd(spi_port_pkg::STATUS_OFS, v);
		`CHECK(v[0], 1'b1, "transmit buffer full")
		wait_bytes(n0 + 5);
		`CHECK(m_rx, 8'h24, "last kept word sent")
		rd(spi_port_pkg::STATUS_OFS, v);
		`CHECK(v[1:0], 2'b10, "buffer drained, empty flag")
		rd(spi_port_pkg::RX_DATA_OFS, v);
	endtask
	// Receive-driven mode: a receive read starts one byte, then it stops
	task automatic t_mode0();
		wr(spi_port_pkg::CFG_OFS, 8'h04);
		wr(spi_port_pkg::TX_DATA_OFS, 8'h33);
		repeat (200) @(posedge clock);
		rd(spi_port_pkg::STATUS_OFS, v);
		`CHECK(v[7], 1'b0, "write alone starts nothing")
		`CHECK(v[1], 1'b0, "transmit write clears its flag")
		n0 = m_n;
		rd(spi_port_pkg::RX_DATA_OFS, v);
		wait_bytes(n0 + 1);
		`CHECK(irq_req, 1'b1, "irq on new receive byte")
		repeat (300) @(posedge clock);
		`CHECK(m_n, n0 + 1, "stopped on unread byte")
		rd(spi_port_pkg::STATUS_OFS, v);
		`CHECK(v[7], 1'b0, "not busy while stopped")
		// Leave mode 0 first, so this clearing read starts no byte
		wr(spi_port_pkg::CFG_OFS, 8'h05);
		rd(spi_port_pkg::RX_DATA_OFS, v);
	endtask
	// Select driven active by another master during a master byte
	task automatic t_multi_master_error();
		wr(spi_port_pkg::CFG_OFS, 8'h0d);
		wr(spi_port_pkg::TX_DATA_OFS, 8'h77);
		repeat (10) @(posedge clock); #2;
		ss_force = 1'b1;
		repeat (10) @(posedge clock); #2;
		ss_force = 1'b0;
		rd(spi_port_pkg::STATUS_OFS, v);
		`CHECK(v[6], 1'b1, "multi-master error set")
		`CHECK(v[7], 1'b0, "abort stops the byte")
		rd(spi_port_pkg::STATUS_OFS, v);
		`CHECK(v[6], 1'b0, "multi-master error cleared")
	endtask
	// Slave role: the bench is master at 200 ns per bit, MSB first
	task automatic t_slave();
		int i;
		logic [7:0] b;
		logic [7:0] got;
		b = 8'ha3;
		got = 8'h00;
		wr(spi_port_pkg::CFG_OFS, 8'h01);
		wr(spi_port_pkg::TX_DATA_OFS, 8'h5a);
		ss_force = 1'b1;
		repeat (8) @(posedge clock);
		#2;
		for (i = 7; i >= 0; i--) begin
			m_mosi = b[i];
			repeat (4) @(posedge clock);
			#2;
			got[i] = miso_w;
			m_sclk = 1'b1;
			repeat (4) @(posedge clock);
			#2;
			m_sclk = 1'b0;
		end
		repeat (6) @(posedge clock);
		rd(spi_port_pkg::STATUS_OFS, v);
		`CHECK(v[7], 1'b1, "busy as slave")
		`CHECK(got, 8'h5a, "slave bits out")
		ss_force = 1'b0;
		repeat (6) @(posedge clock);
		rd(spi_port_pkg::STATUS_OFS, v);
		`CHECK(v[7], 1'b0, "slave idle when deselected")
		`CHECK(v[4], 1'b1, "receive flag as slave")
		rd(spi_port_pkg::RX_DATA_OFS, v);
		`CHECK(v, 8'ha3, "slave bits in")
	endtask
	// ==========================================================
	// Main sequence: 5 cycles of reset, then every scenario
	initial begin
		repeat (5) @(posedge clock);
		#2;
		rst_n = 1'b1;
		t_reset();
		t_order();
		t_overflow(1'b0);
		t_overflow(1'b1);
		t_fill();
		t_mode0();
		t_multi_master_error();
		t_slave();
		final_report();
	end
endmodule
`default_nettype wire
